// ==== rtl/oat_defs.vh ====
// Purpose: constants for the operand address translator
// Assumes: word-indexed register port, 16-bit data
// Notes:   definitions only
`ifndef OAT_DEFS_VH
`define OAT_DEFS_VH

// ----------------------------------------------------------------
// address modes
// ----------------------------------------------------------------
`define OAT_MODE_ABS 2'h0
`define OAT_MODE_VPT 2'h1
`define OAT_MODE_REL 2'h2
`define OAT_MODE_IND 2'h3

// ----------------------------------------------------------------
// operand word layout
// ----------------------------------------------------------------
`define OAT_MODE_HI 15
`define OAT_MODE_LO 14
`define OAT_COORD_HI 13

// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define OAT_REG_SCALE_X 4'h0
`define OAT_REG_SCALE_Y 4'h1
`define OAT_REG_VPORT_X 4'h2
`define OAT_REG_VPORT_Y 4'h3
`define OAT_REG_PEN_X 4'h4
`define OAT_REG_PEN_Y 4'h5
`define OAT_REG_FERR_X 4'h6
`define OAT_REG_FERR_Y 4'h7
`define OAT_REG_STATUS 4'h8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define OAT_RST_SCALE 15'h0000
`define OAT_RST_FERR 15'h0000
`define OAT_RST_COORD 14'h0000

`endif

// ==== rtl/oat_translator.v ====
// Purpose: turn one operand coordinate pair into effective X,Y addresses
// Assumes: single clock, decoder and memory controller on same clock
// Notes:   indirect pairs are fetched one word at a time, chains allowed
//          factors, viewport and pen come in over the register port
//          an evaluation never moves the pen; software does that
`timescale 1ns/100ps
`include "oat_defs.vh"

module oat_translator (
	input wire clock_in,
	input wire rst_n_in,
	// register port
	input wire [3:0] reg_addr_in,
	input wire [15:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [15:0] reg_rdata_out,
	// operand request from the decoder
	input wire op_valid_in,
	input wire [1:0] addr_mode_field_in,
	input wire [13:0] x_coord_field_in,
	input wire [15:0] y_coord_field_in,
	output wire op_ready_out,
	// evaluated address
	output reg eff_valid_out,
	output reg [13:0] eff_x_out,
	output reg [13:0] eff_y_out,
	// indirect fetch from display memory
	output wire mem_req_out,
	output reg [13:0] mem_x_out,
	output reg [13:0] mem_y_out,
	output wire [1:0] mem_plane_out,
	input wire mem_ack_in,
	input wire [15:0] mem_rdata_in
);

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_EVAL = 2'h1;
	// each fetch state waits for its own acknowledge
	localparam ST_FETCH0 = 2'h2;
	localparam ST_FETCH1 = 2'h3;

	// ----------------------------------------------------------------
	// per-axis evaluation, used once for X and once for Y
	// ----------------------------------------------------------------
	// returns {new fractional error, effective address}
	function [28:0] oat_axis;
		input [1:0] mode;
		input [13:0] coord;
		input [14:0] scale;
		input [13:0] refpos;
		input [14:0] ferr;
		input y_axis;
		reg signed [29:0] prod;
		reg [28:0] acc;
		reg [13:0] ipart;
		reg [13:0] base;
		reg scaled;
		reg offset_mode;
		begin
			offset_mode = (mode == `OAT_MODE_VPT) ||
				(mode == `OAT_MODE_REL);
			// absolute and indirect never scale
			scaled = offset_mode && (scale != `OAT_RST_SCALE);
			// a 14 by 16 bit signed product always fits in 29 bits
			// signed field times unsigned factor
			prod = $signed(coord) * $signed({1'b0, scale});
			acc = prod[28:0];
			// only relative mode folds in the old error
			if (mode == `OAT_MODE_REL) begin
				acc = acc + {14'h0000, ferr};
			end
			// negative products floor toward minus infinity
			// integer part only, fraction dropped
			ipart = scaled ? acc[28:15] : coord;
			base = offset_mode ? refpos : `OAT_RST_COORD;
			// positive Y goes up from the reference
			// absolute Y grows downward from top left
			// sums wrap to 14 bits without a flag
			if (offset_mode && y_axis) begin
				oat_axis[13:0] = base - ipart;
			end else begin
				oat_axis[13:0] = base + ipart;
			end
			// error is replaced only when scaled
			oat_axis[28:14] = scaled ? acc[14:0] : ferr;
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	// operand as latched or as fetched, fed to both axes
	reg [1:0] mode_r;
	reg [13:0] x_r;
	reg [13:0] y_r;
	reg [14:0] scale_x_r;
	reg [14:0] scale_y_r;
	reg [13:0] vport_x_r;
	reg [13:0] vport_y_r;
	reg [13:0] pen_x_r;
	reg [13:0] pen_y_r;
	reg [14:0] ferr_x_r;
	reg [14:0] ferr_y_r;
	reg [15:0] word0_r;
	reg [7:0] chain_cnt_r;

	wire [28:0] res_x;
	wire [28:0] res_y;
	wire [13:0] ref_x;
	wire [13:0] ref_y;
	wire op_take;
	wire eval_done;

	// reference is viewport or pen depending on the mode
	// absolute and indirect ignore it inside oat_axis
	assign ref_x = (mode_r == `OAT_MODE_VPT) ? vport_x_r : pen_x_r;
	assign ref_y = (mode_r == `OAT_MODE_VPT) ? vport_y_r : pen_y_r;

	// each axis evaluated on its own factor and error
	assign res_x = oat_axis(mode_r, x_r, scale_x_r, ref_x, ferr_x_r,
		1'b0);
	assign res_y = oat_axis(mode_r, y_r, scale_y_r, ref_y, ferr_y_r,
		1'b1);

	assign op_ready_out = (state_r == ST_IDLE);
	assign op_take = op_valid_in && op_ready_out;
	assign eval_done = (state_r == ST_EVAL) &&
		(mode_r != `OAT_MODE_IND);
	// request stays up until the memory acknowledges
	assign mem_req_out = (state_r == ST_FETCH0) ||
		(state_r == ST_FETCH1);
	// pointer pair always sits in plane 0
	assign mem_plane_out = 2'h0;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// next state: indirect goes out to memory, else finish
	// no loop guard: a pointer cycle in memory keeps the block busy
	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: begin
			if (op_take) begin
				state_nxt = ST_EVAL;
			end
		end
		ST_EVAL: begin
			if (mode_r == `OAT_MODE_IND) begin
				state_nxt = ST_FETCH0;
			end else begin
				state_nxt = ST_IDLE;
			end
		end
		ST_FETCH0: begin
			if (mem_ack_in) begin
				state_nxt = ST_FETCH1;
			end
		end
		ST_FETCH1: begin
			if (mem_ack_in) begin
				state_nxt = ST_EVAL;
			end
		end
		default: begin
			state_nxt = ST_IDLE;
		end
		endcase
	end

	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// operand latch and indirect fetch
	// ----------------------------------------------------------------
	// the fetched pair overwrites the operand, so any mode may follow
	// top two Y bits are assumed zero by the source and dropped
	// low X pointer bits are not checked
	// chain_cnt_r counts the indirect levels of the current operand
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			mode_r <= `OAT_MODE_ABS;
			x_r <= `OAT_RST_COORD;
			y_r <= `OAT_RST_COORD;
			word0_r <= 16'h0000;
			mem_x_out <= `OAT_RST_COORD;
			mem_y_out <= `OAT_RST_COORD;
			chain_cnt_r <= 8'h00;
		end else begin
			if (op_take) begin
				mode_r <= addr_mode_field_in;
				x_r <= x_coord_field_in;
				y_r <= y_coord_field_in[13:0];
				chain_cnt_r <= 8'h00;
			end
			if (state_r == ST_EVAL && mode_r == `OAT_MODE_IND) begin
				// pointer taken as integer, first word at X,Y
				mem_x_out <= x_r;
				mem_y_out <= y_r;
				chain_cnt_r <= chain_cnt_r + 8'h01;
			end
			if (state_r == ST_FETCH0 && mem_ack_in) begin
				word0_r <= mem_rdata_in;
				mem_y_out <= mem_y_out + 14'h0001;
			end
			if (state_r == ST_FETCH1 && mem_ack_in) begin
				mode_r <= word0_r[`OAT_MODE_HI:`OAT_MODE_LO];
				x_r <= word0_r[`OAT_COORD_HI:0];
				y_r <= mem_rdata_in[`OAT_COORD_HI:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// result and error accumulators
	// ----------------------------------------------------------------
	// outputs are held until the next result; error follows the mode
	// eval_done is low in an indirect eval, so a chain gives one pulse
	// each axis keeps its error through unscaled modes
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			eff_valid_out <= 1'b0;
			eff_x_out <= `OAT_RST_COORD;
			eff_y_out <= `OAT_RST_COORD;
			ferr_x_r <= `OAT_RST_FERR;
			ferr_y_r <= `OAT_RST_FERR;
		end else begin
			eff_valid_out <= eval_done;
			if (eval_done) begin
				eff_x_out <= res_x[13:0];
				eff_y_out <= res_y[13:0];
				ferr_x_r <= res_x[28:14];
				ferr_y_r <= res_y[28:14];
			end else if (reg_wr_in) begin
				// software may preload the error; evaluation wins
				if (reg_addr_in == `OAT_REG_FERR_X) begin
					ferr_x_r <= reg_wdata_in[14:0];
				end
				if (reg_addr_in == `OAT_REG_FERR_Y) begin
					ferr_y_r <= reg_wdata_in[14:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// changing a factor mid-operand is legal but races the evaluation
	// unmapped indices are dropped; the status word is read only
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scale_x_r <= `OAT_RST_SCALE;
			scale_y_r <= `OAT_RST_SCALE;
			vport_x_r <= `OAT_RST_COORD;
			vport_y_r <= `OAT_RST_COORD;
			pen_x_r <= `OAT_RST_COORD;
			pen_y_r <= `OAT_RST_COORD;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
			`OAT_REG_SCALE_X: begin
				scale_x_r <= reg_wdata_in[14:0];
			end
			`OAT_REG_SCALE_Y: begin
				scale_y_r <= reg_wdata_in[14:0];
			end
			`OAT_REG_VPORT_X: begin
				vport_x_r <= reg_wdata_in[13:0];
			end
			`OAT_REG_VPORT_Y: begin
				vport_y_r <= reg_wdata_in[13:0];
			end
			`OAT_REG_PEN_X: begin
				pen_x_r <= reg_wdata_in[13:0];
			end
			`OAT_REG_PEN_Y: begin
				pen_y_r <= reg_wdata_in[13:0];
			end
			default: begin
				pen_y_r <= pen_y_r;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	// data one cycle after the strobe, zero otherwise and when unmapped
	// status packs chain depth, current mode and sequencer state
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
			`OAT_REG_SCALE_X: begin
				reg_rdata_out <= {1'b0, scale_x_r};
			end
			`OAT_REG_SCALE_Y: begin
				reg_rdata_out <= {1'b0, scale_y_r};
			end
			`OAT_REG_VPORT_X: begin
				reg_rdata_out <= {2'h0, vport_x_r};
			end
			`OAT_REG_VPORT_Y: begin
				reg_rdata_out <= {2'h0, vport_y_r};
			end
			`OAT_REG_PEN_X: begin
				reg_rdata_out <= {2'h0, pen_x_r};
			end
			`OAT_REG_PEN_Y: begin
				reg_rdata_out <= {2'h0, pen_y_r};
			end
			`OAT_REG_FERR_X: begin
				reg_rdata_out <= {1'b0, ferr_x_r};
			end
			`OAT_REG_FERR_Y: begin
				reg_rdata_out <= {1'b0, ferr_y_r};
			end
			`OAT_REG_STATUS: begin
				reg_rdata_out <= {chain_cnt_r, 4'h0, mode_r, state_r};
			end
			default: begin
				reg_rdata_out <= 16'h0000;
			end
			endcase
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

endmodule

// ==== dv/oat_monitor.sv ====
// Purpose: port-level checks for the operand address translator
// Assumes: no register writes while an operand is being evaluated
// Notes:   shadows mirror register writes seen on the port
`timescale 1ns/100ps
module oat_monitor (
	input wire clock_in,
	input wire rst_n_in,
	input wire [3:0] reg_addr_in,
	input wire [15:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [15:0] reg_rdata_out,
	input wire op_valid_in,
	input wire [1:0] addr_mode_field_in,
	input wire [13:0] x_coord_field_in,
	input wire [15:0] y_coord_field_in,
	input wire op_ready_out,
	input wire eff_valid_out,
	input wire [13:0] eff_x_out,
	input wire [13:0] eff_y_out,
	input wire mem_req_out,
	input wire [13:0] mem_x_out,
	input wire [13:0] mem_y_out,
	input wire [1:0] mem_plane_out,
	input wire mem_ack_in,
	input wire [15:0] mem_rdata_in
);
	reg [14:0] sx_r, sy_r;
	reg [13:0] vx_r, vy_r, px_r, py_r;
	reg ws_r;
	wire take = op_valid_in && op_ready_out;
	wire [1:0] md = addr_mode_field_in;
	wire [13:0] fy = y_coord_field_in[13:0];
	// ----------------------------------------------------------------
	// shadow registers
	// ----------------------------------------------------------------
	// ws_r tells first from second word of a pair fetch
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sx_r <= 15'h0000;
			sy_r <= 15'h0000;
			vx_r <= 14'h0000;
			vy_r <= 14'h0000;
			px_r <= 14'h0000;
			py_r <= 14'h0000;
			ws_r <= 1'b0;
		end else begin
			if (reg_wr_in && reg_addr_in == 4'h0) sx_r <= reg_wdata_in[14:0];
			if (reg_wr_in && reg_addr_in == 4'h1) sy_r <= reg_wdata_in[14:0];
			if (reg_wr_in && reg_addr_in == 4'h2) vx_r <= reg_wdata_in[13:0];
			if (reg_wr_in && reg_addr_in == 4'h3) vy_r <= reg_wdata_in[13:0];
			if (reg_wr_in && reg_addr_in == 4'h4) px_r <= reg_wdata_in[13:0];
			if (reg_wr_in && reg_addr_in == 4'h5) py_r <= reg_wdata_in[13:0];
			if (mem_req_out && mem_ack_in) ws_r <= ~ws_r;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	a_plane_zero: assert property (mem_plane_out == 2'h0)
		else $error("fetch plane not zero");
	a_req_hold: assert property (mem_req_out && !mem_ack_in |=>
		mem_req_out && $stable(mem_x_out) && $stable(mem_y_out))
		else $error("fetch request dropped or moved");
	a_word_step: assert property (
		mem_req_out && mem_ack_in && !ws_r |=>
		mem_y_out == 14'($past(mem_y_out) + 14'h0001)
		&& $stable(mem_x_out)) else $error("second word not at y plus one");
	a_abs_eval: assert property (take && md == 2'h0 |-> ##2
		eff_valid_out && eff_x_out == $past(x_coord_field_in, 2)
		&& eff_y_out == $past(fy, 2)) else $error("absolute result wrong");
	a_ind_fetch: assert property (take && md == 2'h3 |-> ##2
		mem_req_out && !eff_valid_out
		&& mem_x_out == $past(x_coord_field_in, 2)
		&& mem_y_out == $past(fy, 2)) else $error("indirect pointer wrong");
	a_vpt_x: assert property (
		take && md == 2'h1 && sx_r == 15'h0 |-> ##2
		eff_x_out == 14'($past(x_coord_field_in, 2) + $past(vx_r, 2)))
		else $error("viewport x wrong");
	a_vpt_y: assert property (
		take && md == 2'h1 && sy_r == 15'h0 |-> ##2
		eff_y_out == 14'($past(vy_r, 2) - $past(fy, 2)))
		else $error("viewport y wrong");
	a_rel_x: assert property (
		take && md == 2'h2 && sx_r == 15'h0 |-> ##2
		eff_x_out == 14'($past(x_coord_field_in, 2) + $past(px_r, 2)))
		else $error("relative x wrong");
	a_rel_y: assert property (
		take && md == 2'h2 && sy_r == 15'h0 |-> ##2
		eff_y_out == 14'($past(py_r, 2) - $past(fy, 2)))
		else $error("relative y wrong");
	a_eff_pulse: assert property (eff_valid_out |=> !eff_valid_out)
		else $error("result strobe longer than a cycle");
endmodule
bind oat_translator oat_monitor oat_monitor_i (.*);

// ==== dv/oat_mem_model.sv ====
// Purpose: display memory holding indirect operand pairs
// Assumes: one request at a time, held until acknowledged
// Notes:   latency alternates between prompt and slow
`timescale 1ns/100ps
module oat_mem_model (
	input wire clock_in,
	input wire rst_n_in,
	input wire req_in,
	input wire [13:0] x_in,
	input wire [13:0] y_in,
	input wire [1:0] plane_in,
	output reg ack_out,
	output reg [15:0] rdata_out
);
	reg [1:0] cnt_r;
	reg slow_r;
	// stored pairs in plane 0; a second pair chains to the first
	function [15:0] word;
		input [29:0] a;
		case (a)
			{2'h0, 14'h0100, 14'h0020}: word = 16'h004d;
			{2'h0, 14'h0100, 14'h0021}: word = 16'h0037;
			{2'h0, 14'h0200, 14'h0030}: word = 16'hc100;
			{2'h0, 14'h0200, 14'h0031}: word = 16'h0020;
			default: word = 16'hffff;
		endcase
	endfunction
	// idle data bus toggles so a stale word is never mistaken for data
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_out <= 1'b0;
			rdata_out <= 16'h0000;
			cnt_r <= 2'h0;
			slow_r <= 1'b0;
		end else begin
			ack_out <= 1'b0;
			rdata_out <= ~rdata_out;
			if (req_in && !ack_out) begin
				if (cnt_r == (slow_r ? 2'h3 : 2'h0)) begin
					ack_out <= 1'b1;
					rdata_out <= word({plane_in, x_in, y_in});
					cnt_r <= 2'h0;
					slow_r <= ~slow_r;
				end else begin
					cnt_r <= cnt_r + 2'h1;
				end
			end
		end
	end
endmodule

// ==== dv/tb.sv ====
// Purpose: directed tests of the operand address translator
// Assumes: fixed-point scale with 15 fraction bits
// Notes:   pen y 100, viewport at 10,50 unless rewritten
`timescale 1ns/100ps
`include "oat_defs.vh"
module tb;
	reg clock_in = 1'b0;
	reg rst_n_in = 1'b0;
	reg [3:0] reg_addr_in = 4'h0;
	reg [15:0] reg_wdata_in = 16'h0000;
	reg reg_wr_in = 1'b0, reg_rd_in = 1'b0, op_valid_in = 1'b0;
	reg [1:0] addr_mode_field_in = 2'h0;
	reg [13:0] x_coord_field_in = 14'h0000;
	reg [15:0] y_coord_field_in = 16'h0000;
	wire [15:0] reg_rdata_out, mem_rdata_in;
	wire op_ready_out, eff_valid_out, mem_req_out, mem_ack_in;
	wire [13:0] eff_x_out, eff_y_out, mem_x_out, mem_y_out;
	wire [1:0] mem_plane_out;
	integer error_cnt = 0, cmp_count = 0, cyc = 0;
	always #5 clock_in = ~clock_in;
	oat_translator oat_translator_i (.*);
	oat_mem_model oat_mem_model_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.req_in(mem_req_out), .x_in(mem_x_out), .y_in(mem_y_out),
		.plane_in(mem_plane_out), .ack_out(mem_ack_in),
		.rdata_out(mem_rdata_in));
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				error_cnt = error_cnt + 1;
				$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		begin
			@(posedge clock_in);
			reg_wr_in <= 1'b1;
			reg_addr_in <= a;
			reg_wdata_in <= d;
			@(posedge clock_in);
			reg_wr_in <= 1'b0;
		end
	endtask
	// read data stand only in the cycle after the strobe
	task rd(input [3:0] a, input [15:0] e);
		begin
			@(posedge clock_in);
			reg_rd_in <= 1'b1;
			reg_addr_in <= a;
			@(posedge clock_in);
			reg_rd_in <= 1'b0;
			#1 chk(reg_rdata_out, e);
		end
	endtask
	// top Y bits kept zero by the source
	task op(input [1:0] m, input [13:0] x, input [13:0] y,
		input [13:0] ex, input [13:0] ey);
		begin
			@(posedge clock_in);
			op_valid_in <= 1'b1;
			addr_mode_field_in <= m;
			x_coord_field_in <= x;
			y_coord_field_in <= {2'b00, y};
			@(negedge clock_in);
			while (op_ready_out !== 1'b1) @(negedge clock_in);
			@(posedge clock_in);
			op_valid_in <= 1'b0;
			@(negedge clock_in);
			while (eff_valid_out !== 1'b1) @(negedge clock_in);
			chk({2'b00, eff_x_out}, {2'b00, ex});
			chk({2'b00, eff_y_out}, {2'b00, ey});
		end
	endtask
	task complete_run;
		begin
			$display("[SUM] compares=%0d mismatches=%0d", cmp_count, error_cnt);
			if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
			else $display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// hang guard, well above the hundred or so cycles the tests need
	always @(posedge clock_in) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			complete_run;
		end
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clock_in);
		rst_n_in <= 1'b1;
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
		rd(4'h6, 16'h0000);
		rd(4'h7, 16'h0000);
		rd(4'h9, 16'h0000); // unmapped index
		$display("[TEST] reset values done");
		wr(4'h2, 16'h000a);
		wr(4'h3, 16'h0032);
		wr(4'h4, 16'h00c8);
		wr(4'h5, 16'h0064);
		rd(4'h3, 16'h0032);
		rd(4'h5, 16'h0064);
		op(`OAT_MODE_ABS, 14'h0064, 14'h3fff, 14'h0064, 14'h3fff);
		op(`OAT_MODE_VPT, 14'h0005, 14'h0003, 14'h000f, 14'h002f);
		op(`OAT_MODE_REL, 14'h3ffc, 14'h0007, 14'h00c4, 14'h005d);
		wr(4'h4, 16'h1fff);
		op(`OAT_MODE_REL, 14'h0001, 14'h0000, 14'h2000, 14'h0064);
		$display("[TEST] unscaled modes done");
		wr(4'h0, 16'h4000);
		wr(4'h1, 16'h4000);
		wr(4'h4, 16'h00c8);
		op(`OAT_MODE_VPT, 14'h0003, 14'h0003, 14'h000b, 14'h0031);
		rd(4'h6, 16'h4000);
		rd(4'h7, 16'h4000);
		op(`OAT_MODE_REL, 14'h0003, 14'h0000, 14'h00ca, 14'h0064);
		rd(4'h6, 16'h0000);
		op(`OAT_MODE_VPT, 14'h3ffd, 14'h0000, 14'h0008, 14'h0032);
		rd(4'h6, 16'h4000);
		op(`OAT_MODE_ABS, 14'h0005, 14'h0005, 14'h0005, 14'h0005);
		rd(4'h6, 16'h4000);
		// Y unscaled while X stays scaled; Y error must survive
		wr(4'h1, 16'h0000);
		wr(4'h7, 16'h1234);
		op(`OAT_MODE_VPT, 14'h0003, 14'h0003, 14'h000b, 14'h002f);
		rd(4'h7, 16'h1234);
		$display("[TEST] scaled modes done");
		// pointers keep the low four X bits zero
		op(`OAT_MODE_IND, 14'h0100, 14'h0020, 14'h004d, 14'h0037);
		op(`OAT_MODE_IND, 14'h0200, 14'h0030, 14'h004d, 14'h0037);
		// two indirect levels counted, then absolute, idle
		rd(4'h8, 16'h0200);
		$display("[TEST] indirect done");
		complete_run;
	end
endmodule
